// file: rtl/mtp_bus_consts.svh
`ifndef MTP_BUS_CONSTS_SVH
`define MTP_BUS_CONSTS_SVH

// ----------------------------------------
// Bus widths and command codes
// ----------------------------------------
`define ADDR_W          21
`define DATA_W          16
`define UNLOCK1_ADDR    21'h000555
`define UNLOCK2_ADDR    21'h0002AA
`define UNLOCK1_DATA    16'h00AA
`define UNLOCK2_DATA    16'h0055
`define CMD_AUTOSEL     16'h0090
`define CMD_SECURE_IN   16'h0088
`define CMD_PROGRAM     16'h00A0
`define CMD_RESET       16'h00F0
`define CMD_SECURE_OUT  16'h0000
`define ASEL_MAKER_ADDR 21'h000000
`define ASEL_PART_ADDR  21'h000001
`define ASEL_LOCK_ADDR  21'h000003
`define LOCK_BIT_POS    7

// ----------------------------------------
// Timing (clk at 40 MHz)
// ----------------------------------------
`define CLK_PERIOD_NS   25
`define ACCESS_NS       120
`define SETUP_NS        50
`define PULSE_NS        50
`define RST_PULSE_NS    500
`define RST_RECOVER_NS  50
`define ACCESS_CYC      ((`ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SETUP_CYC       ((`SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PULSE_CYC       ((`PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RST_PULSE_CYC   ((`RST_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RST_RECOVER_CYC ((`RST_RECOVER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNT_W           6

`endif

// file: rtl/mtp_bus_pkg.sv
package mtp_bus_pkg;

  typedef enum logic [2:0] {
    OP_READ    = 3'h0,
    OP_WRITE   = 3'h1,
    OP_AUTOSEL = 3'h2,
    OP_SEC_IN  = 3'h3,
    OP_SEC_OUT = 3'h4,
    OP_RESET   = 3'h5,
    OP_HWRST   = 3'h6,
    OP_PROGRAM = 3'h7
  } op_t;

  typedef struct packed {
    op_t         op;
    logic [20:0] addr;
    logic [15:0] data;
  } req_t;

  typedef struct packed {
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
    logic        reset_n;
    logic        id_high_voltage_level;
  } ctl_t;

  typedef enum logic [8:0] {
    ST_IDLE   = 9'h001,
    ST_SETUP  = 9'h002,
    ST_STROBE = 9'h004,
    ST_HOLD   = 9'h008,
    ST_RDWAIT = 9'h010,
    ST_RDCAP  = 9'h020,
    ST_RSTLOW = 9'h040,
    ST_RSTREC = 9'h080,
    ST_NEXT   = 9'h100
  } state_t;

endpackage

// file: rtl/mtp_bus_host.sv
`timescale 1ns/1ps
`include "mtp_bus_consts.svh"
`default_nettype none

// Summary of operation
// - Read: select and output gate low, write strobe high, address held valid.
// - Write: strobe and select low, output gate held high.
// - Host raises reissue_needed when a hardware reset follows a program; it does not reissue it.
// - Maker or part code is read through autoselect, address bit 0 picking which.
// - Region entry is two unlock writes then the entry command.
module mtp_bus_host (
  input  wire logic                clk,
  input  wire logic                sys_rst,
  input  wire mtp_bus_pkg::req_t   req,
  input  wire logic                req_valid,
  output logic                     req_ready,
  output logic [15:0]              rsp_data,
  output logic                     rsp_valid,
  output logic                     reissue_needed,
  output logic                     secure_mapped,
  output mtp_bus_pkg::ctl_t        ctl,
  output logic [20:0]              addr,
  output logic [15:0]              dq_out,
  output logic                     dq_oe,
  input  wire logic [15:0]         dq_in
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  mtp_bus_pkg::state_t state_ff;
  mtp_bus_pkg::state_t nxt_state;
  mtp_bus_pkg::req_t   cur_ff;
  logic [`CNT_W-1:0]   cnt_ff;
  logic [`CNT_W-1:0]   nxt_cnt;
  logic [1:0]          step_ff;
  logic [1:0]          nxt_step;
  logic [15:0]         rdata_ff;
  logic                rvalid_ff;
  logic                reissue_ff;
  logic                secure_ff;
  logic                prog_ff;
  // Pin input passes three stages; change counts once stages two and three agree
  logic [15:0]         dq_s1_ff;
  logic [15:0]         dq_s2_ff;
  logic [15:0]         dq_s3_ff;
  logic [15:0]         dq_stable_ff;

  function automatic logic [`CNT_W-1:0] cyc(input int n);
    cyc = (n < 1) ? `CNT_W'(1) : `CNT_W'(n);
  endfunction

  // ----------------------------------------
  // Sequence decode
  // ----------------------------------------
  // Index of the last bus cycle per operation; each starts unlock1, unlock2, command
  wire       is_cmd    = (cur_ff.op == mtp_bus_pkg::OP_AUTOSEL) || (cur_ff.op == mtp_bus_pkg::OP_SEC_IN) ||
                         (cur_ff.op == mtp_bus_pkg::OP_SEC_OUT) || (cur_ff.op == mtp_bus_pkg::OP_PROGRAM);
  wire       is_rd     = (cur_ff.op == mtp_bus_pkg::OP_READ);
  wire [1:0] last_step = (cur_ff.op == mtp_bus_pkg::OP_SEC_IN) ? 2'h2 : 2'h3;

  wire [20:0] seq_addr = (step_ff == 2'h0) ? `UNLOCK1_ADDR :
                         (step_ff == 2'h1) ? `UNLOCK2_ADDR :
                         (step_ff == 2'h2) ? `UNLOCK1_ADDR : cur_ff.addr;
  wire [15:0] cmd_code = (cur_ff.op == mtp_bus_pkg::OP_AUTOSEL) ? `CMD_AUTOSEL :
                         (cur_ff.op == mtp_bus_pkg::OP_SEC_IN)  ? `CMD_SECURE_IN :
                         (cur_ff.op == mtp_bus_pkg::OP_SEC_OUT) ? `CMD_AUTOSEL : `CMD_PROGRAM;
  wire [15:0] last_dat = (cur_ff.op == mtp_bus_pkg::OP_SEC_OUT) ? `CMD_SECURE_OUT : cur_ff.data;
  wire [15:0] seq_data = (step_ff == 2'h0) ? `UNLOCK1_DATA :
                         (step_ff == 2'h1) ? `UNLOCK2_DATA :
                         (step_ff == 2'h2) ? cmd_code : last_dat;
  // Autoselect fourth cycle is a read of the code address
  wire        asel_rd  = (cur_ff.op == mtp_bus_pkg::OP_AUTOSEL) && (step_ff == 2'h3);
  wire [15:0] wdata    = (cur_ff.op == mtp_bus_pkg::OP_RESET) ? `CMD_RESET :
                         is_cmd ? seq_data : cur_ff.data;
  wire [20:0] waddr    = is_cmd ? seq_addr : cur_ff.addr;
  wire        rd_phase = is_rd || asel_rd;
  wire        dq_same  = (dq_s2_ff == dq_s3_ff);

  // ----------------------------------------
  // Control state machine
  // ----------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = (cnt_ff != `CNT_W'(0)) ? cnt_ff - `CNT_W'(1) : cnt_ff;
    nxt_step  = step_ff;
    case (state_ff)
      mtp_bus_pkg::ST_IDLE: begin
        nxt_step = 2'h0;
        if (req_valid) begin
          nxt_state = (req.op == mtp_bus_pkg::OP_HWRST) ? mtp_bus_pkg::ST_RSTLOW : mtp_bus_pkg::ST_SETUP;
          nxt_cnt   = (req.op == mtp_bus_pkg::OP_HWRST) ? cyc(`RST_PULSE_CYC) : cyc(`SETUP_CYC);
        end
      end
      mtp_bus_pkg::ST_SETUP: begin
        if (cnt_ff == `CNT_W'(1)) begin
          nxt_state = rd_phase ? mtp_bus_pkg::ST_RDWAIT : mtp_bus_pkg::ST_STROBE;
          nxt_cnt   = rd_phase ? cyc(`ACCESS_CYC + 3) : cyc(`PULSE_CYC);
        end
      end
      mtp_bus_pkg::ST_STROBE: begin
        if (cnt_ff == `CNT_W'(1)) begin
          nxt_state = mtp_bus_pkg::ST_HOLD;
          nxt_cnt   = cyc(`PULSE_CYC);
        end
      end
      mtp_bus_pkg::ST_HOLD: begin
        if (cnt_ff == `CNT_W'(1)) begin
          nxt_state = (is_cmd && (step_ff != last_step)) ? mtp_bus_pkg::ST_NEXT : mtp_bus_pkg::ST_IDLE;
        end
      end
      mtp_bus_pkg::ST_NEXT: begin
        nxt_step  = step_ff + 2'h1;
        nxt_state = mtp_bus_pkg::ST_SETUP;
        nxt_cnt   = cyc(`SETUP_CYC);
      end
      mtp_bus_pkg::ST_RDWAIT: begin
        // Counter parks at zero, so a slow device keeps the wait open until data settles
        if ((cnt_ff <= `CNT_W'(1)) && dq_same) begin
          nxt_state = mtp_bus_pkg::ST_RDCAP;
        end
      end
      mtp_bus_pkg::ST_RDCAP: begin
        nxt_state = mtp_bus_pkg::ST_IDLE;
      end
      mtp_bus_pkg::ST_RSTLOW: begin
        if (cnt_ff == `CNT_W'(1)) begin
          nxt_state = mtp_bus_pkg::ST_RSTREC;
          nxt_cnt   = cyc(`RST_RECOVER_CYC);
        end
      end
      mtp_bus_pkg::ST_RSTREC: begin
        if (cnt_ff == `CNT_W'(1)) begin
          nxt_state = mtp_bus_pkg::ST_IDLE;
        end
      end
      default: begin
        nxt_state = mtp_bus_pkg::ST_IDLE;
      end
    endcase
  end

  wire take   = (state_ff == mtp_bus_pkg::ST_IDLE) && req_valid;
  wire rd_cap = (state_ff == mtp_bus_pkg::ST_RDCAP);
  wire wr_end = (state_ff == mtp_bus_pkg::ST_HOLD) && (cnt_ff == `CNT_W'(1)) &&
                !(is_cmd && (step_ff != last_step));
  wire rst_end = (state_ff == mtp_bus_pkg::ST_RSTLOW) && (cnt_ff == `CNT_W'(1));

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_ff <= mtp_bus_pkg::ST_IDLE;
      cnt_ff   <= `CNT_W'(0);
      step_ff  <= 2'h0;
      cur_ff   <= '0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      step_ff  <= nxt_step;
      if (take) begin
        cur_ff <= req;
      end
    end
  end

  // ----------------------------------------
  // Data capture and tracking flags
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dq_s1_ff     <= 16'h0000;
      dq_s2_ff     <= 16'h0000;
      dq_s3_ff     <= 16'h0000;
      dq_stable_ff <= 16'h0000;
    end else begin
      dq_s1_ff <= dq_in;
      dq_s2_ff <= dq_s1_ff;
      dq_s3_ff <= dq_s2_ff;
      if (dq_same) begin
        dq_stable_ff <= dq_s3_ff;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_ff   <= 16'h0000;
      rvalid_ff  <= 1'b0;
      reissue_ff <= 1'b0;
      secure_ff  <= 1'b0;
      prog_ff    <= 1'b0;
    end else begin
      rvalid_ff <= rd_cap;
      if (rd_cap) begin
        rdata_ff <= dq_stable_ff;
      end
      // A hardware reset cuts short any program in flight; flag it for resubmit
      if (rst_end) begin
        reissue_ff <= prog_ff;
        secure_ff  <= 1'b0;
        prog_ff    <= 1'b0;
      end else if (wr_end) begin
        if (cur_ff.op == mtp_bus_pkg::OP_SEC_IN) begin
          secure_ff <= 1'b1;
        end else if (cur_ff.op == mtp_bus_pkg::OP_SEC_OUT) begin
          secure_ff <= 1'b0;
        end
        prog_ff <= (cur_ff.op == mtp_bus_pkg::OP_PROGRAM);
      end else if (take && (req.op != mtp_bus_pkg::OP_HWRST)) begin
        reissue_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Pin drive
  // ----------------------------------------
  wire strobing = (state_ff == mtp_bus_pkg::ST_STROBE);
  wire active   = (state_ff != mtp_bus_pkg::ST_IDLE) && (state_ff != mtp_bus_pkg::ST_RSTLOW) &&
                  (state_ff != mtp_bus_pkg::ST_RSTREC) && (state_ff != mtp_bus_pkg::ST_NEXT);
  wire rd_pins  = active && rd_phase;
  wire wr_pins  = active && !rd_phase;

  // Select stays low through the strobe so the device latches on the strobe edges
  assign ctl.ce_n    = !active;
  assign ctl.oe_n    = !(rd_pins && (state_ff != mtp_bus_pkg::ST_SETUP));
  assign ctl.we_n    = !(wr_pins && strobing);
  assign ctl.reset_n = (state_ff != mtp_bus_pkg::ST_RSTLOW);
  // High-voltage identifier read is not produced by this controller
  assign ctl.id_high_voltage_level = 1'b0;
  assign addr        = active ? (rd_phase ? cur_ff.addr : waddr) : 21'h000000;
  assign dq_out      = wdata;
  assign dq_oe       = wr_pins;
  assign req_ready   = (state_ff == mtp_bus_pkg::ST_IDLE);
  assign rsp_data    = rdata_ff;
  assign rsp_valid   = rvalid_ff;
  assign reissue_needed = reissue_ff;
  assign secure_mapped  = secure_ff;

endmodule

`default_nettype wire

// file: testbench/mtp_bus_host_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// Pin sequencing checks
// ----
module mtp_bus_host_asserts (
  input wire logic              clk,
  input wire logic              sys_rst,
  input wire logic              req_ready,
  input wire logic              rsp_valid,
  input wire mtp_bus_pkg::ctl_t ctl,
  input wire logic [20:0]       addr,
  input wire logic [15:0]       dq_out,
  input wire logic              dq_oe
);
  logic [7:0] lo_cnt_ff;
  // Counts low cycles of the reset pin so the pulse width can be judged
  always_ff @(posedge clk) begin
    if (sys_rst || ctl.reset_n)
      lo_cnt_ff <= 8'h00;
    else
      lo_cnt_ff <= lo_cnt_ff + 8'h01;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  read_gate_a: assert property (!ctl.oe_n |-> !ctl.ce_n && ctl.we_n && !dq_oe)
    else $error("read gate wrong");
  write_gate_a: assert property (!ctl.we_n |-> !ctl.ce_n && ctl.oe_n && dq_oe)
    else $error("write gate wrong");
  strobe_len_a: assert property ($fell(ctl.we_n) |-> ##1 !ctl.we_n ##1 ctl.we_n)
    else $error("strobe width wrong");
  wr_stable_a: assert property (!ctl.we_n |-> $stable(addr) && $stable(dq_out))
    else $error("write bus moved");
  rst_len_a: assert property ($rose(ctl.reset_n) |-> lo_cnt_ff >= 8'h14)
    else $error("reset pulse short");
  rst_quiet_a: assert property (!ctl.reset_n |-> ctl.ce_n && ctl.we_n && !dq_oe)
    else $error("cycle during reset");
  id_off_a: assert property (!ctl.id_high_voltage_level)
    else $error("id level raised");
  rsp_after_a: assert property (rsp_valid |-> !$past(ctl.oe_n, 2) && !$past(rsp_valid))
    else $error("response without read");
  idle_rest_a: assert property (req_ready |-> ctl.ce_n && ctl.reset_n && addr == 21'h000000)
    else $error("idle not standby");
  cover property ($rose(ctl.reset_n));
  cover property (rsp_valid);
  cover property ($fell(ctl.we_n));
endmodule
`default_nettype wire

// file: testbench/mtp_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// Memory device model
// ----
module mtp_dev_model #(
  parameter logic [15:0] MAKER  = 16'h0001, // Arbitrary value
  parameter logic [15:0] PART   = 16'h0002, // Arbitrary value
  parameter bit          LOCKED = 1'b1
) (
  input wire logic              clk,
  input wire mtp_bus_pkg::ctl_t ctl,
  input wire logic [20:0]       addr,
  input wire logic [15:0]       dq_out,
  input wire logic [2:0]        lat,
  output logic [15:0]           dq_in
);
  logic [15:0] mem [16];
  logic [20:0] wa;
  logic [1:0]  step;
  logic        asel;
  logic        sec;
  logic [2:0]  cnt;
  wire drive = !ctl.ce_n && !ctl.oe_n && ctl.reset_n;
  wire code = asel || ctl.id_high_voltage_level;
  wire [15:0] cval = addr[1:0] == 2'h0 ? MAKER : addr[1:0] == 2'h1 ? PART : {8'h00, LOCKED, 7'h08};
  wire [15:0] sval = 16'h5EC0 ^ {7'h00, addr[8:0]};
  wire [15:0] rval = code ? cval : (sec && addr < 21'h000200) ? sval : mem[addr[3:0]];
  initial begin
    for (int i = 0; i < 16; i++)
      mem[i] = 16'hA000 + 16'(i);
    step = 2'h0;
    asel = 1'b0;
    sec = 1'b0;
    cnt = 3'h0;
    dq_in = 16'h0000;
  end
  always @(negedge ctl.we_n) if (!ctl.ce_n) wa = addr;
  always @(negedge ctl.reset_n) begin
    step = 2'h0;
    asel = 1'b0;
    sec = 1'b0;
  end
  always @(posedge ctl.we_n) if (!ctl.ce_n && ctl.oe_n && ctl.reset_n) begin
    if (dq_out == 16'h00F0) begin
      step = 2'h0;
      asel = 1'b0;
    end else if (step == 2'h3) begin
      if (!(sec && wa < 21'h000200)) mem[wa[3:0]] = dq_out;
      step = 2'h0;
    end else if (asel && dq_out == 16'h0000) begin
      sec = 1'b0;
      asel = 1'b0;
    end else if (step == 2'h0)
      step = (wa[10:0] == 11'h555 && dq_out == 16'h00AA) ? 2'h1 : 2'h0;
    else if (step == 2'h1)
      step = (wa[10:0] == 11'h2AA && dq_out == 16'h0055) ? 2'h2 : 2'h0;
    else begin
      asel = dq_out == 16'h0090;
      sec = sec | (dq_out == 16'h0088);
      step = dq_out == 16'h00A0 ? 2'h3 : 2'h0;
    end
  end
  // Released bus toggles so a stale value can never pass as data
  always @(posedge clk) begin
    cnt <= drive ? (cnt == lat ? cnt : cnt + 3'h1) : 3'h0;
    dq_in <= (drive && cnt == lat) ? rval : ~dq_in;
  end
endmodule
`default_nettype wire

// file: testbench/mtp_bus_host_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
module mtp_bus_host_tb;
  localparam logic [15:0] MAKER = 16'h1357; // Arbitrary value
  localparam logic [15:0] PART  = 16'h2468; // Arbitrary value
  logic clk, sys_rst, req_valid;
  mtp_bus_pkg::req_t req;
  mtp_bus_pkg::ctl_t ctl;
  logic [2:0] lat;
  logic req_ready, rsp_valid, reissue_needed, secure_mapped, dq_oe;
  logic [20:0] addr, a;
  logic [15:0] rsp_data, dq_out, dq_in, got, d;
  logic [15:0] shadow [16];
  int n_mismatch, checks, seed;
  mtp_bus_host dut (.clk(clk), .sys_rst(sys_rst), .req(req), .req_valid(req_valid),
    .req_ready(req_ready), .rsp_data(rsp_data), .rsp_valid(rsp_valid),
    .reissue_needed(reissue_needed), .secure_mapped(secure_mapped), .ctl(ctl),
    .addr(addr), .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in));
  mtp_dev_model #(.MAKER(MAKER), .PART(PART), .LOCKED(1'b1)) mem (.clk(clk), .ctl(ctl),
    .addr(addr), .dq_out(dq_out), .lat(lat), .dq_in(dq_in));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  function automatic logic [15:0] sec_w(input logic [20:0] x);
    return 16'h5EC0 ^ {7'h00, x[8:0]};
  endfunction
  task automatic results;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic run(input mtp_bus_pkg::op_t o, input logic [20:0] x, input logic [15:0] y);
    int i;
    @(posedge clk);
    req <= '{o, x, y};
    req_valid <= 1'b1;
    lat <= 3'($random(seed));
    i = 0;
    got = 16'hXXXX;
    do begin @(posedge clk); i++; end while (req_ready !== 1'b1 && i < 400);
    req_valid <= 1'b0;
    do begin @(posedge clk); i++; if (rsp_valid === 1'b1) got = rsp_data; end
    while (req_ready !== 1'b1 && i < 900);
    if (i >= 900) begin n_mismatch++; results(); end
  endtask
  task automatic rd(input logic [20:0] x);
    run(mtp_bus_pkg::OP_READ, x, 16'h0000);
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    results();
  end
  initial begin
    seed = 32'h369c;
    sys_rst = 1'b1;
    req_valid = 1'b0;
    req = '0;
    lat = 3'h0;
    n_mismatch = 0;
    checks = 0;
    got = 16'h0000;
    for (int k = 0; k < 16; k++)
      shadow[k] = 16'hA000 + 16'(k);
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    // ----
    // Array reads and programs
    // ----
    for (int k = 0; k < 6; k++) begin
      a = 21'($random(seed));
      d = 16'($random(seed));
      rd(a);
      `CHK("array", shadow[a[3:0]], got)
      run(mtp_bus_pkg::OP_PROGRAM, a, d);
      shadow[a[3:0]] = d;
      rd(a);
      `CHK("program", d, got)
    end
    // ----
    // Codes, reset command, broken sequence
    // ----
    run(mtp_bus_pkg::OP_AUTOSEL, 21'h000000, 16'h0000);
    `CHK("maker", MAKER, got)
    run(mtp_bus_pkg::OP_AUTOSEL, 21'h000001, 16'h0000);
    `CHK("part", PART, got)
    run(mtp_bus_pkg::OP_AUTOSEL, 21'h000003, 16'h0000);
    `CHK("lock", 1'b1, got[7])
    run(mtp_bus_pkg::OP_RESET, 21'($random(seed)), 16'h00F0);
    rd(21'h000005);
    `CHK("reset cmd", shadow[5], got)
    run(mtp_bus_pkg::OP_WRITE, 21'h000555, 16'h00AA);
    run(mtp_bus_pkg::OP_WRITE, 21'h0002AB, 16'h0055);
    run(mtp_bus_pkg::OP_WRITE, 21'h000555, 16'h0090);
    rd(21'h000001);
    `CHK("bad seq", shadow[1], got)
    // ----
    // Secured region and hardware reset
    // ----
    run(mtp_bus_pkg::OP_SEC_IN, 21'h000000, 16'h0000);
    `CHK("mapped", 1'b1, secure_mapped)
    run(mtp_bus_pkg::OP_PROGRAM, 21'h000006, 16'h1111);
    rd(21'h000006);
    `CHK("sec word", sec_w(21'h000006), got)
    rd(21'h000206);
    `CHK("high array", shadow[6], got)
    run(mtp_bus_pkg::OP_SEC_OUT, 21'h000000, 16'h0000);
    rd(21'h000006);
    `CHK("sec exit", shadow[6], got)
    run(mtp_bus_pkg::OP_SEC_IN, 21'h000000, 16'h0000);
    a = 21'($random(seed)) | 21'h000200;
    d = 16'($random(seed));
    run(mtp_bus_pkg::OP_PROGRAM, a, d);
    shadow[a[3:0]] = d;
    run(mtp_bus_pkg::OP_HWRST, 21'h000000, 16'h0000);
    `CHK("unmapped", 1'b0, secure_mapped)
    `CHK("reissue", 1'b1, reissue_needed)
    rd(a & 21'h0001FF);
    `CHK("after reset", shadow[a[3:0]], got)
    results();
  end
endmodule
bind mtp_bus_host mtp_bus_host_asserts chk (.clk(clk), .sys_rst(sys_rst), .req_ready(req_ready),
  .rsp_valid(rsp_valid), .ctl(ctl), .addr(addr), .dq_out(dq_out), .dq_oe(dq_oe));
`default_nettype wire
